//--- logic/timer_bank_pkg.sv
// Constants and carrier types for the prescaled countdown timer bank.
// Assumes an 8-bit internal I/O bus synchronous to the peripheral clock.
package timer_bank_pkg;

    // Register offsets on the internal I/O bus.
    localparam logic [7:0] OFS_STATUS_ENABLE = 8'hA0;
    localparam logic [7:0] OFS_PRESCALER_RELOAD = 8'hA3;
    localparam logic [7:0] OFS_BANK_CONFIG = 8'hA4;
    localparam logic [7:0] OFS_BAUD0_RELOAD = 8'hA9;
    localparam logic [7:0] OFS_BAUD1_RELOAD = 8'hAB;
    localparam logic [7:0] OFS_BAUD2_RELOAD = 8'hAD;
    localparam logic [7:0] OFS_BAUD3_RELOAD = 8'hAF;

    // Field positions in the status/enable register.
    localparam int BIT_BANK_ENABLE = 0;
    localparam int BIT_PRESCALER_FLAG = 1;
    localparam int BIT_BAUD_FLAG_LO = 4;

    // Field positions in the configuration register.
    localparam int BIT_PRIO_LO = 0;
    localparam int BIT_SRC_LO = 4;

    // Values after reset.
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [1:0] PRIO_OFF = 2'h0;

    // Peripheral clock cycles per timer clock cycle.
    localparam int HALF_DIV_CYCLES = 2;

    // One access on the internal I/O bus.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;

endpackage

//--- logic/countdown_unit.sv
// One reloadable down counter with its one-timer-clock output pulse.
// Assumes tick is a one-cycle strobe at half the peripheral clock rate.
`timescale 1ns/100ps
module countdown_unit #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Timing
    input wire logic tick,
    input wire logic enable,
    input wire logic in_pulse,
    // Setup
    input wire logic [CNT_W-1:0] reload,
    // Results
    output logic out_pulse_r,
    output logic fire
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic step;
    logic at_zero;
    logic out_pulse_nxt;

    if (CNT_W < 1 || CNT_W > 8)
    begin : g_bad_width
        $error("CNT_W must lie between 1 and 8");
    end

    // Counting happens at the tick where the incoming pulse ends.
    assign step = tick & enable & in_pulse;
    assign at_zero = (count_r == '0);
    assign fire = step & at_zero;
    assign count_nxt = !step ? count_r : (at_zero ? reload : count_r - 1'b1);
    assign out_pulse_nxt = !enable ? 1'b0 : (tick ? fire : out_pulse_r);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= timer_bank_pkg::RST_COUNT[CNT_W-1:0];
            out_pulse_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            out_pulse_r <= out_pulse_nxt;
        end
    end

    chk_reload_on_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fire |=> count_r == $past(reload))
        else $error("counter did not reload after reaching zero");

    chk_hold_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !enable |=> $stable(count_r) && !out_pulse_r)
        else $error("counter moved while disabled");

    chk_pulse_one_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fire ##1 enable) |-> out_pulse_r ##1 out_pulse_r)
        else $error("output pulse shorter than one timer period");

    chk_pulse_ends: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (out_pulse_r && tick && !fire) |=> !out_pulse_r)
        else $error("output pulse longer than one timer period");

    chk_decrement_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (step && !at_zero) |=> count_r == $past(count_r) - 1'b1)
        else $error("counter did not decrement");

endmodule // countdown_unit

//--- logic/prescaled_countdown_timer_bank.sv
// Timer bank top: I/O registers, halved clock tick, five countdown units, flags and interrupt.
// Assumes the processor I/O bus is synchronous to clk_sys and gives one-cycle rd and wr strobes.
`timescale 1ns/100ps
// Contract
// - Five timers: prescaler plus four 8-bit baud.
// - Reload 0..255 divides input rate by n+1.
// - Reload zero passes every input pulse through.
// - Bank runs from peripheral clock halved.
// - Status bit 0 write enables the bank.
// - Each output pulse lasts one timer period.
// - Counters step when input pulse ends.
// - At zero, next input reloads and pulses.
// - Reload registers writable any time, safely.
// - Baud timers drive serial ports in order.
// - All timers share one interrupt and priority.
// - Done flags at bits 1, 7..4.
// - Status read returns flags then clears them.
// - Pulse during status read is never lost.
// - Status write sets write-only interrupt enables.
// - Interrupt while an enabled flag is set and the priority field is not zero.
// - Bits 3,2 read zero; bit 0 write-only.
// - Bank enable cleared at reset.
// - Config bit picks baud source per timer.
// - Two-bit config field sets interrupt priority.
// - New reload sets next cycle's period.
module prescaled_countdown_timer_bank #(
    parameter int NUM_BAUD = 4,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Internal I/O bus
    input wire timer_bank_pkg::io_req_t io_req,
    output logic [7:0] io_rdata_r,
    // Serial port baud clocks
    output logic [NUM_BAUD-1:0] baud_clk_r,
    // Interrupt request
    output logic irq_req_r,
    output logic [1:0] irq_prio_r
);

    if (NUM_BAUD != 4)
    begin : g_bad_baud
        $error("NUM_BAUD must be 4 to fit the status register layout");
    end
    if (CNT_W < 1 || CNT_W > 8)
    begin : g_bad_width
        $error("CNT_W must lie between 1 and 8");
    end

    localparam int NUM_TIMERS = NUM_BAUD + 1;
    localparam logic [7:0] BAUD_OFS [4] = '{timer_bank_pkg::OFS_BAUD0_RELOAD,
        timer_bank_pkg::OFS_BAUD1_RELOAD, timer_bank_pkg::OFS_BAUD2_RELOAD,
        timer_bank_pkg::OFS_BAUD3_RELOAD};

    // Register state.
    logic bank_en_r;
    logic [CNT_W-1:0] pre_reload_r;
    logic [CNT_W-1:0] baud_reload_r [NUM_BAUD];
    logic [7:0] config_r;
    logic [NUM_TIMERS-1:0] irq_en_r;
    logic [NUM_TIMERS-1:0] done_r;
    logic [NUM_TIMERS-1:0] done_nxt;
    logic half_phase_r;

    // Bus decode.
    logic wr_status;
    logic wr_pre;
    logic wr_config;
    logic rd_status;
    logic [NUM_BAUD-1:0] wr_baud;
    logic [7:0] status_view;
    logic [7:0] rdata_nxt;
    logic [NUM_TIMERS-1:0] clear_mask;

    // Timer signals.
    logic tick;
    logic pre_pulse;
    logic pre_fire;
    logic [NUM_BAUD-1:0] baud_pulse;
    logic [NUM_BAUD-1:0] baud_fire;
    logic [NUM_TIMERS-1:0] fire_all;
    logic [NUM_BAUD-1:0] baud_src;
    logic irq_nxt;
    logic [1:0] prio_code;

    assign wr_status = io_req.wr && (io_req.addr == timer_bank_pkg::OFS_STATUS_ENABLE);
    assign wr_pre = io_req.wr && (io_req.addr == timer_bank_pkg::OFS_PRESCALER_RELOAD);
    assign wr_config = io_req.wr && (io_req.addr == timer_bank_pkg::OFS_BANK_CONFIG);
    assign rd_status = io_req.rd && (io_req.addr == timer_bank_pkg::OFS_STATUS_ENABLE);

    // Status layout: prescaler flag at bit 1, baud flags at bits 7..4, others zero.
    assign status_view = {done_r[NUM_TIMERS-1:1], 2'h0, done_r[0], 1'h0};
    assign rdata_nxt = rd_status ? status_view : (io_req.rd ? 8'h00 : io_rdata_r);

    // A read clears exactly the flags it returned; a fresh fire sets again.
    assign clear_mask = rd_status ? done_r : '0;
    assign done_nxt = (done_r & ~clear_mask) | fire_all;

    // Timer clock is the peripheral clock halved, gated by the bank enable.
    assign tick = half_phase_r & bank_en_r;

    assign baud_src = config_r[timer_bank_pkg::BIT_SRC_LO +: NUM_BAUD];
    assign fire_all = {baud_fire, pre_fire};
    assign irq_nxt = (|(done_nxt & irq_en_r))
        && (config_r[timer_bank_pkg::BIT_PRIO_LO +: 2] != timer_bank_pkg::PRIO_OFF);
    assign prio_code = config_r[timer_bank_pkg::BIT_PRIO_LO +: 2];

    countdown_unit #(
        .CNT_W(CNT_W)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick),
        .enable(bank_en_r),
        .in_pulse(1'b1),
        .reload(pre_reload_r),
        .out_pulse_r(pre_pulse),
        .fire(pre_fire)
    );

    // Each baud timer counts either every tick or on each prescaler pulse.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BAUD; gi++)
        begin : g_baud
            logic src_pulse;
            assign src_pulse = baud_src[gi] ? pre_pulse : 1'b1;
            assign wr_baud[gi] = io_req.wr && (io_req.addr == BAUD_OFS[gi]);

            countdown_unit #(
                .CNT_W(CNT_W)
            ) u_baud (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .tick(tick),
                .enable(bank_en_r),
                .in_pulse(src_pulse),
                .reload(baud_reload_r[gi]),
                .out_pulse_r(baud_pulse[gi]),
                .fire(baud_fire[gi])
            );

            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                    baud_reload_r[gi] <= timer_bank_pkg::RST_RELOAD[CNT_W-1:0];
                else if (wr_baud[gi])
                    baud_reload_r[gi] <= io_req.wdata[CNT_W-1:0];
            end

            chk_reload_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
                wr_baud[gi] |=> baud_reload_r[gi] == $past(io_req.wdata[CNT_W-1:0]))
                else $error("baud reload write not taken");
        end
    endgenerate

    // Free-running half-rate phase.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            half_phase_r <= 1'b0;
        else
            half_phase_r <= ~half_phase_r;
    end

    // Control registers written by the processor.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bank_en_r <= 1'b0;
            irq_en_r <= '0;
            config_r <= timer_bank_pkg::RST_CONFIG;
            pre_reload_r <= timer_bank_pkg::RST_RELOAD[CNT_W-1:0];
        end
        else
        begin
            if (wr_status)
            begin
                bank_en_r <= io_req.wdata[timer_bank_pkg::BIT_BANK_ENABLE];
                irq_en_r <= {io_req.wdata[timer_bank_pkg::BIT_BAUD_FLAG_LO +: NUM_BAUD],
                    io_req.wdata[timer_bank_pkg::BIT_PRESCALER_FLAG]};
            end
            if (wr_config)
                config_r <= io_req.wdata;
            if (wr_pre)
                pre_reload_r <= io_req.wdata[CNT_W-1:0];
        end
    end

    // Flags, read data and outputs.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_r <= '0;
            io_rdata_r <= 8'h00;
            irq_req_r <= 1'b0;
            irq_prio_r <= timer_bank_pkg::PRIO_OFF;
            baud_clk_r <= '0;
        end
        else
        begin
            done_r <= done_nxt;
            io_rdata_r <= rdata_nxt;
            irq_req_r <= irq_nxt;
            irq_prio_r <= config_r[timer_bank_pkg::BIT_PRIO_LO +: 2];
            baud_clk_r <= baud_pulse;
        end
    end

    chk_flag_set_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fire_all[0] |=> done_r[0])
        else $error("prescaler fire lost its flag");

    chk_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_status && done_r[1] && !baud_fire[0]) |=> !done_r[1] && io_rdata_r[4])
        else $error("status read did not return and clear flag");

    chk_read_zero_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_status |=> io_rdata_r[3:0] == {2'b00, $past(done_r[0]), 1'b0})
        else $error("status low bits wrong");

    chk_enable_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_status && !io_req.wdata[0]) |=> !tick ##1 !tick)
        else $error("bank ticks while disabled");

    chk_irq_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((done_nxt & irq_en_r) == '0) |=> !irq_req_r)
        else $error("interrupt without enabled flag");

    chk_no_fire_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !bank_en_r |-> fire_all == '0)
        else $error("fire while bank disabled");

    chk_baud_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        baud_pulse[2] |=> baud_clk_r[2])
        else $error("baud clock does not follow timer");

    chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick |=> !tick)
        else $error("tick faster than half rate");

    chk_rdata_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_status |=> io_rdata_r[7:4] == $past(done_r[NUM_TIMERS-1:1]))
        else $error("status read lost baud flags");

    chk_rdata_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (io_req.rd && !rd_status) |=> io_rdata_r == 8'h00)
        else $error("read of other address not zero");

    chk_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !io_req.rd |=> $stable(io_rdata_r))
        else $error("read data changed without a read");

    chk_flags_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!rd_status && fire_all == '0) |=> $stable(done_r))
        else $error("flags changed without fire or read");

    chk_read_clears_all: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_status && fire_all == '0) |=> done_r == '0)
        else $error("status read left a flag set");

    chk_fire_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fire_all != '0) |=> (done_r & $past(fire_all)) == $past(fire_all))
        else $error("timer fire did not set its flag");

    chk_read_keeps_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_status && baud_fire[3]) |=> done_r[4])
        else $error("fire during status read was lost");

    chk_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status |=> bank_en_r == $past(io_req.wdata[timer_bank_pkg::BIT_BANK_ENABLE]))
        else $error("bank enable write not taken");

    chk_enable_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_status |=> $stable(bank_en_r))
        else $error("bank enable changed without a write");

    chk_irq_en_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status |=> irq_en_r == {$past(io_req.wdata[7:4]), $past(io_req.wdata[1])})
        else $error("interrupt enable write not taken");

    chk_irq_en_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_status |=> $stable(irq_en_r))
        else $error("interrupt enables changed without a write");

    chk_prio_off_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (prio_code == timer_bank_pkg::PRIO_OFF) |=> !irq_req_r)
        else $error("interrupt requested with priority off");

    chk_irq_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((done_nxt & irq_en_r) != '0 && prio_code != timer_bank_pkg::PRIO_OFF) |=> irq_req_r)
        else $error("enabled flag raised no interrupt");

    chk_irq_has_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq_req_r |-> irq_prio_r != timer_bank_pkg::PRIO_OFF)
        else $error("interrupt request without a priority");

    chk_prio_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> irq_prio_r == $past(prio_code))
        else $error("priority output does not follow config");

    chk_config_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_config |=> config_r == $past(io_req.wdata))
        else $error("config write not taken");

    chk_config_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_config |=> $stable(config_r))
        else $error("config changed without a write");

    chk_pre_reload_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_pre |=> pre_reload_r == $past(io_req.wdata[CNT_W-1:0]))
        else $error("prescaler reload write not taken");

    chk_pre_reload_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_pre |=> $stable(pre_reload_r))
        else $error("prescaler reload changed without a write");

    chk_half_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> half_phase_r != $past(half_phase_r))
        else $error("half rate phase did not toggle");

    chk_tick_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !bank_en_r |-> !tick)
        else $error("tick while bank disabled");

    chk_pulses_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !bank_en_r |=> baud_pulse == '0 && !pre_pulse)
        else $error("timer pulse while bank disabled");

    chk_flags_frozen_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!bank_en_r && !rd_status) |=> $stable(done_r))
        else $error("flags changed while bank disabled");

    chk_fire_on_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fire_all != '0) |-> tick)
        else $error("timer fired off the half rate tick");

    chk_baud_all_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> baud_clk_r == $past(baud_pulse))
        else $error("baud clocks do not follow their timers");

    chk_prescaled_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tick && baud_src[0] && !pre_pulse) |-> !baud_fire[0])
        else $error("prescaled baud timer fired without prescaler pulse");

endmodule // prescaled_countdown_timer_bank

//--- verification/baud_port_model.sv
// Serial port baud input model: counts baud clock pulses and measures period and width.
// Assumes the baud clock is sampled on the rising edge of clk_sys.
`timescale 1ns/100ps
module baud_port_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Baud clock from the timer bank
    input wire logic baud_in,
    // Measurements
    output logic [15:0] rise_count_r,
    output logic [15:0] last_period_r,
    output logic [15:0] last_high_r
);
    logic prev_r;
    logic [15:0] since_rise_r;
    logic [15:0] high_run_r;
    wire rise = baud_in && !prev_r;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_r <= 1'b0;
            since_rise_r <= 16'h0000;
            high_run_r <= 16'h0000;
            rise_count_r <= 16'h0000;
            last_period_r <= 16'h0000;
            last_high_r <= 16'h0000;
        end
        else
        begin
            prev_r <= baud_in;
            since_rise_r <= rise ? 16'h0001 : since_rise_r + 16'h0001;
            high_run_r <= baud_in ? high_run_r + 16'h0001 : 16'h0000;
            if (rise)
            begin
                rise_count_r <= rise_count_r + 16'h0001;
                last_period_r <= since_rise_r;
            end
            if (!baud_in && prev_r)
                last_high_r <= high_run_r;
        end
    end
endmodule // baud_port_model

//--- verification/prescaled_countdown_timer_bank_tb_top.sv
// Testbench for the timer bank: register tasks, baud clock measurements, flags and interrupt.
// Assumes the timer bank package, the design and the baud port model are compiled first.
`timescale 1ns/100ps
module prescaled_countdown_timer_bank_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    timer_bank_pkg::io_req_t io_req = '0;
    logic [7:0] io_rdata_r;
    logic [3:0] baud_clk_r;
    logic irq_req_r;
    logic [1:0] irq_prio_r;
    wire [3:0][15:0] rise_count;
    wire [3:0][15:0] last_period;
    wire [3:0][15:0] last_high;
    logic [15:0] saved_count [4];
    logic [7:0] rd_val;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [7:0] ADDRS [4] = '{timer_bank_pkg::OFS_BAUD0_RELOAD,
        timer_bank_pkg::OFS_BAUD1_RELOAD, timer_bank_pkg::OFS_BAUD2_RELOAD,
        timer_bank_pkg::OFS_BAUD3_RELOAD};
    localparam logic [7:0] RELOADS [4] = '{8'h02, 8'h00, 8'h01, 8'h04};
    localparam logic [15:0] PERIODS [4] = '{16'h0006, 16'h0008, 16'h0010, 16'h000A};
    localparam logic [7:0] STAT = timer_bank_pkg::OFS_STATUS_ENABLE;
    localparam logic [7:0] CFG = timer_bank_pkg::OFS_BANK_CONFIG;
    always #50 clk_sys = ~clk_sys;
    prescaled_countdown_timer_bank u_prescaled_countdown_timer_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .io_req(io_req),
        .io_rdata_r(io_rdata_r),
        .baud_clk_r(baud_clk_r),
        .irq_req_r(irq_req_r),
        .irq_prio_r(irq_prio_r)
    );
    for (genvar i = 0; i < 4; i++)
    begin : g_port
        baud_port_model u_baud_port_model (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .baud_in(baud_clk_r[i]),
            .rise_count_r(rise_count[i]),
            .last_period_r(last_period[i]),
            .last_high_r(last_high[i])
        );
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        io_req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(negedge clk_sys);
        io_req.wr = 1'b0;
    endtask
    task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        io_req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk_sys);
        io_req.rd = 1'b0;
        @(negedge clk_sys);
        data = io_rdata_r;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    initial
    begin
        idle(3);
        rst_n = 1'b1;
        io_read(STAT, rd_val);
        check(16'(rd_val), 16'h0000);
        check(16'(irq_req_r), 16'h0000);
        idle(20);
        check(rise_count[0], 16'h0000);
        // Prescaler divides by 4; baud1 and baud2 run from it, baud0 and baud3 from pclk/2.
        io_write(timer_bank_pkg::OFS_PRESCALER_RELOAD, 8'h03);
        for (int i = 0; i < 4; i++)
            io_write(ADDRS[i], RELOADS[i]);
        io_write(CFG, 8'h61);
        io_write(STAT, 8'h13);
        idle(100);
        for (int i = 0; i < 4; i++)
        begin
            check(last_period[i], PERIODS[i]);
            check(last_high[i], 16'h0002);
        end
        check(16'(irq_req_r), 16'h0001);
        check(16'(irq_prio_r), 16'h0001);
        // A new reload while running sets the following period.
        io_write(timer_bank_pkg::OFS_BAUD0_RELOAD, 8'h05);
        idle(40);
        check(last_period[0], 16'h000C);
        io_write(STAT, 8'h00);
        idle(2);
        check(16'(irq_req_r), 16'h0000);
        io_write(STAT, 8'h12);
        idle(2);
        check(16'(irq_req_r), 16'h0001);
        for (int i = 0; i < 4; i++)
            saved_count[i] = rise_count[i];
        io_read(STAT, rd_val);
        check(16'(rd_val), 16'h00F2);
        idle(2);
        check(16'(irq_req_r), 16'h0000);
        io_read(STAT, rd_val);
        check(16'(rd_val), 16'h0000);
        io_read(CFG, rd_val);
        check(16'(rd_val), 16'h0000);
        for (int i = 0; i < 4; i++)
            check(rise_count[i], saved_count[i]);
        for (int p = 0; p < 4; p++)
        begin
            io_write(CFG, 8'(p));
            idle(2);
            check(16'(irq_prio_r), 16'(p));
        end
        // Priority off silences a pending request; a reset stops a running bank.
        io_write(STAT, 8'h13);
        idle(20);
        check(16'(irq_req_r), 16'h0001);
        io_write(CFG, 8'h00);
        idle(2);
        check(16'(irq_req_r), 16'h0000);
        @(negedge clk_sys);
        rst_n = 1'b0;
        idle(3);
        rst_n = 1'b1;
        idle(20);
        for (int i = 0; i < 4; i++)
            check(rise_count[i], 16'h0000);
        io_read(STAT, rd_val);
        check(16'(rd_val), 16'h0000);
        stop_test();
    end
endmodule // prescaled_countdown_timer_bank_tb_top
